// ===== core/cbted_consts.svh
// offsets, field positions and reset values of the bit timing block
`ifndef CBTED_CONSTS_SVH
`define CBTED_CONSTS_SVH

`define CBTED_CFG_OFS      8'h00
`define CBTED_STAT_OFS     8'h04

`define CBTED_PSC_MSB      5
`define CBTED_PSC_LSB      0
`define CBTED_SJW_MSB      7
`define CBTED_SJW_LSB      6
`define CBTED_SAM_BIT      14
`define CBTED_PH2SEL_BIT   15
`define CBTED_PH1_MSB      18
`define CBTED_PH1_LSB      16
`define CBTED_PH2_MSB      21
`define CBTED_PH2_LSB      19
`define CBTED_PROP_MSB     24
`define CBTED_PROP_LSB     22

`define CBTED_CFG_RST      32'h0092_8000
`define CBTED_CFG_MASK     32'h01ff_c0ff

`define CBTED_BIT_TQ_MIN   6'h08
`define CBTED_BIT_TQ_MAX   6'h19
`define CBTED_CRC_POLY     15'h4599
`define CBTED_STUFF_RUN    3'h5
`define CBTED_EOF_LAST     3'h6

`define CBTED_ERR_BIT      0
`define CBTED_ERR_ACK      1
`define CBTED_ERR_FORM     2
`define CBTED_ERR_STUFF    3
`define CBTED_ERR_CRC      4
`define CBTED_ST_CFG_REJ   5
`define CBTED_ST_RX_LVL    6

`endif

// ===== core/cbted_ctl_end.sv
// controller end: ahb-lite register slave holding the timing word
`timescale 1ns/1ns
`include "cbted_consts.svh"

module cbted_ctl_end
  import cbted_pkg::*;
(
  input  logic        hclk,
  input  logic        hresetn,
  cbted_link_if.ctl   link,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic [31:0] hrdata,
  output logic        hresp
);

  localparam cbted_ctl_st_type CTL_RST = '{
    cfg: `CBTED_CFG_RST, hreadyout: 1'b1, default: '0
  };

  cbted_ctl_st_type st_ff;
  cbted_ctl_st_type nxt_st;

  logic       ap;
  logic       upper_ok;
  logic [5:0] w_prop;
  logic [5:0] w_ph1;
  logic [5:0] w_ph2;
  logic [5:0] w_sjw;
  logic [5:0] w_tot;
  logic       cfg_ok;

  assign ap       = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign upper_ok = haddr[31:8] == 24'h0;
  assign w_prop   = {3'h0, hwdata[`CBTED_PROP_MSB:`CBTED_PROP_LSB]} + 6'h1;
  assign w_ph1    = {3'h0, hwdata[`CBTED_PH1_MSB:`CBTED_PH1_LSB]} + 6'h1;
  assign w_ph2    = hwdata[`CBTED_PH2SEL_BIT] ?
                    {3'h0, hwdata[`CBTED_PH2_MSB:`CBTED_PH2_LSB]} + 6'h1 : w_ph1;
  assign w_sjw    = {4'h0, hwdata[`CBTED_SJW_MSB:`CBTED_SJW_LSB]} + 6'h1;
  assign w_tot    = 6'h1 + w_prop + w_ph1 + w_ph2;
  // any whole-quantum bit time keeps the quantum an integer multiple
  assign cfg_ok = (w_tot >= `CBTED_BIT_TQ_MIN) && (w_tot <= `CBTED_BIT_TQ_MAX) &&
                  (w_prop + w_ph1 >= w_ph2) &&
                  (w_ph2 > w_sjw);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.hreadyout = 1'b1;
    nxt_st.hresp     = 1'b0;
    // a refused word leaves the running timing untouched
    if (st_ff.dp_wr && st_ff.dp_cfg) begin
      if (cfg_ok) begin
        nxt_st.cfg = hwdata & `CBTED_CFG_MASK;
      end else begin
        nxt_st.status[`CBTED_ST_CFG_REJ] = 1'b1;
      end
    end
    if (st_ff.dp_wr && st_ff.dp_stat) begin
      nxt_st.status = nxt_st.status & ~hwdata[5:0];
    end
    // set after clear so an error in the clearing cycle survives
    nxt_st.status[4:0] = nxt_st.status[4:0] | link.err;
    nxt_st.dp_wr   = ap & hwrite;
    nxt_st.dp_cfg  = upper_ok && haddr[7:0] == `CBTED_CFG_OFS;
    nxt_st.dp_stat = upper_ok && haddr[7:0] == `CBTED_STAT_OFS;
    // read data from next values so a read right after a write sees it
    if (ap && !hwrite) begin
      if (nxt_st.dp_cfg) begin
        nxt_st.hrdata = nxt_st.cfg;
      end else if (nxt_st.dp_stat) begin
        nxt_st.hrdata = {25'h0, link.rx_bit, nxt_st.status};
      end else begin
        nxt_st.hrdata = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= CTL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.hreadyout;
  assign hrdata    = st_ff.hrdata;
  assign hresp     = st_ff.hresp;
  assign link.cfg  = st_ff.cfg;

endmodule

// ===== core/cbted_dev_end.sv
// bit timing, sampling, synchronisation and error detection end
`timescale 1ns/1ns
`include "cbted_consts.svh"

// Contract
// - bit time is 8 to 25 quanta
// - sync, prop, phase one, phase two in order
// - phase two programmed or copied from phase one
// - sample at phase one / phase two boundary
// - select bit 14 picks three-sample majority
// - hard sync only on start-of-frame falling edge
// - late edge lengthens, early edge shortens phase
// - adjustment capped by jump width field 7:6
// - quantum is system clock over 2*(prescaler+1)
// - prop plus phase one not below phase two
// - phase two longer than jump width
// - quantum rate an integer multiple of bit rate
// - transmitter flags readback mismatch as bit error
// - no bit error for a recessive bit sent in arbitration or ack
// - passive error frame dominant readback is fine
// - missing ack flags ack error, repeat message; only the ack error is flagged here, nothing repeats the message
// - illegal level in fixed fields is form error
// - receiver ignores dominant last end-of-frame bit
// - sixth equal stuffed bit is stuff error
// - receiver checks computed crc against received crc
module cbted_dev_end
  import cbted_pkg::*;
(
  input  logic            hclk,
  input  logic            hresetn,
  cbted_link_if.dev       link,
  input  logic            can_rx,
  output logic            can_tx,
  input  cbted_field_type field,
  input  logic            transmitting,
  input  logic            passive_err_frame,
  input  logic            tx_bit,
  output logic            bit_start,
  output logic            rx_valid,
  output logic            rx_level,
  output logic            stuff_bit
);

  localparam cbted_dev_st_type DEV_RST = '{
    rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1, hist: 3'h7, rx_bit: 1'b1,
    can_tx: 1'b1, last_lvl: 1'b1, default: '0
  };

  cbted_dev_st_type st_ff;
  cbted_dev_st_type nxt_st;

  logic [6:0] psc_max;
  logic [2:0] resync_jump_width;
  logic [5:0] prop_len;
  logic [5:0] ph1_len;
  logic [5:0] ph2_len;
  logic [5:0] sp_o;
  logic [5:0] end_o;
  logic [5:0] sp_n;
  logic [5:0] end_n;
  logic [5:0] rem;
  logic [2:0] add_n;
  logic [2:0] sub_n;
  logic       tick;
  logic       edge_fall;
  logic       restart;
  logic       sb;
  logic       stuffed;
  logic       fixed_form;

  assign psc_max  = {link.cfg[`CBTED_PSC_MSB:`CBTED_PSC_LSB], 1'b1};
  assign resync_jump_width      = {1'b0, link.cfg[`CBTED_SJW_MSB:`CBTED_SJW_LSB]} + 3'h1;
  assign prop_len = {3'h0, link.cfg[`CBTED_PROP_MSB:`CBTED_PROP_LSB]} + 6'h1;
  assign ph1_len  = {3'h0, link.cfg[`CBTED_PH1_MSB:`CBTED_PH1_LSB]} + 6'h1;
  // phase two copies phase one unless its own length is selected
  assign ph2_len  = link.cfg[`CBTED_PH2SEL_BIT] ?
                    {3'h0, link.cfg[`CBTED_PH2_MSB:`CBTED_PH2_LSB]} + 6'h1 :
                    ph1_len;
  // >= rather than == so a shrinking prescaler cannot strand the counter
  assign tick      = st_ff.psc >= psc_max;
  assign edge_fall = st_ff.rx_prev & ~st_ff.rx_sync;
  // pos 0 is sync, then prop, phase one, phase two from sp_o on
  assign sp_o  = 6'h1 + prop_len + ph1_len + {3'h0, st_ff.add};
  assign end_o = sp_o + ph2_len - {3'h0, st_ff.sub} - 6'h1;
  assign stuffed    = field inside {fld_sof, fld_arb, fld_ctrl, fld_data, fld_crc};
  assign fixed_form = field inside {fld_crc_del, fld_ack_del, fld_eof, fld_ifs};

  always_comb begin
    nxt_st  = st_ff;
    add_n   = st_ff.add;
    sub_n   = st_ff.sub;
    restart = 1'b0;
    rem     = 6'h0;
    sp_n    = sp_o;
    end_n   = end_o;
    // majority of the last two quanta and the current one
    sb = link.cfg[`CBTED_SAM_BIT] ?
         ((st_ff.hist[1] & st_ff.hist[0]) | (st_ff.hist[1] & st_ff.rx_sync) |
          (st_ff.hist[0] & st_ff.rx_sync)) :
         st_ff.rx_sync;
    nxt_st.rx_meta   = can_rx;
    nxt_st.rx_sync   = st_ff.rx_meta;
    nxt_st.rx_prev   = st_ff.rx_sync;
    nxt_st.sample    = 1'b0;
    nxt_st.bit_start = 1'b0;
    nxt_st.stuff_bit = 1'b0;
    nxt_st.err       = 5'h0;

    if (edge_fall && field == fld_idle && st_ff.rx_bit) begin
      // restart the bit on the edge; the current quantum becomes sync
      nxt_st.psc       = 7'h0;
      nxt_st.pos       = 6'h0;
      nxt_st.add       = 3'h0;
      nxt_st.sub       = 3'h0;
      nxt_st.edge_pend = 1'b0;
      nxt_st.bit_start = 1'b1;
      nxt_st.can_tx    = transmitting ? tx_bit : 1'b1;
      nxt_st.crc       = 15'h0;
      nxt_st.rxcrc     = 15'h0;
      nxt_st.same_cnt  = 3'h0;
    end else begin
      nxt_st.psc = tick ? 7'h0 : st_ff.psc + 7'h1;
      if (tick) begin
        nxt_st.hist      = {st_ff.hist[1:0], st_ff.rx_sync};
        nxt_st.edge_pend = 1'b0;
        if (st_ff.edge_pend) begin
          if (st_ff.pos < sp_o) begin
            add_n = (st_ff.pos < {3'h0, resync_jump_width}) ? st_ff.pos[2:0] : resync_jump_width;
          end else begin
            rem = end_o - st_ff.pos + 6'h1;
            if (rem <= {3'h0, resync_jump_width}) begin
              restart = 1'b1;
            end else begin
              sub_n = resync_jump_width;
            end
          end
        end
        sp_n       = 6'h1 + prop_len + ph1_len + {3'h0, add_n};
        end_n      = sp_n + ph2_len - {3'h0, sub_n} - 6'h1;
        nxt_st.add = add_n;
        nxt_st.sub = sub_n;
        if (restart || st_ff.pos >= end_n) begin
          nxt_st.pos       = restart ? 6'h1 : 6'h0;
          nxt_st.add       = 3'h0;
          nxt_st.sub       = 3'h0;
          nxt_st.bit_start = 1'b1;
          nxt_st.can_tx    = transmitting ? tx_bit : 1'b1;
        end else begin
          nxt_st.pos = st_ff.pos + 6'h1;
          if (st_ff.pos + 6'h1 == sp_n) begin
            nxt_st.sample = 1'b1;
          end
        end
      end
      // edges after a dominant sample or inside sync need no correction
      if (edge_fall && field != fld_idle && st_ff.rx_bit && st_ff.pos != 6'h0) begin
        nxt_st.edge_pend = 1'b1;
      end
    end

    if (nxt_st.sample) begin
      nxt_st.rx_bit = sb;
      if (transmitting && sb != st_ff.can_tx &&
          !(st_ff.can_tx && (field == fld_arb || field == fld_ack_slot)) &&
          !(passive_err_frame && !sb)) begin
        nxt_st.err[`CBTED_ERR_BIT] = 1'b1;
      end
      if (transmitting && field == fld_ack_slot && sb) begin
        nxt_st.err[`CBTED_ERR_ACK] = 1'b1;
      end
      nxt_st.eof_cnt = (field == fld_eof) ? st_ff.eof_cnt + 3'h1 : 3'h0;
      if (fixed_form && !sb &&
          !(!transmitting && field == fld_eof && st_ff.eof_cnt == `CBTED_EOF_LAST)) begin
        nxt_st.err[`CBTED_ERR_FORM] = 1'b1;
      end
      if (stuffed) begin
        if (sb != st_ff.last_lvl) begin
          nxt_st.same_cnt  = 3'h1;
          nxt_st.last_lvl  = sb;
          nxt_st.stuff_bit = st_ff.same_cnt == `CBTED_STUFF_RUN;
        end else if (st_ff.same_cnt == `CBTED_STUFF_RUN) begin
          nxt_st.err[`CBTED_ERR_STUFF] = 1'b1;
          nxt_st.same_cnt              = 3'h0;
        end else begin
          nxt_st.same_cnt = st_ff.same_cnt + 3'h1;
        end
        // stuff bits are dropped before the crc sees the stream
        if (!nxt_st.stuff_bit) begin
          if (field == fld_crc) begin
            nxt_st.rxcrc = {st_ff.rxcrc[13:0], sb};
          end else begin
            nxt_st.crc = {st_ff.crc[13:0], 1'b0} ^
                         ((sb ^ st_ff.crc[14]) ? `CBTED_CRC_POLY : 15'h0);
          end
        end
      end else begin
        nxt_st.same_cnt = 3'h0;
      end
      if (field == fld_crc_del && !transmitting && st_ff.crc != st_ff.rxcrc) begin
        nxt_st.err[`CBTED_ERR_CRC] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= DEV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign can_tx      = st_ff.can_tx;
  assign bit_start   = st_ff.bit_start;
  assign rx_valid    = st_ff.sample;
  assign rx_level    = st_ff.rx_bit;
  assign stuff_bit   = st_ff.stuff_bit;
  assign link.sample = st_ff.sample;
  assign link.rx_bit = st_ff.rx_bit;
  assign link.err    = st_ff.err;

endmodule

// ===== core/cbted_link_if.sv
// link between the bit timing end and the controller end
`timescale 1ns/1ns
interface cbted_link_if;
  logic [31:0] cfg;
  logic        sample;
  logic        rx_bit;
  logic [4:0]  err;

  modport dev (input cfg, output sample, output rx_bit, output err);
  modport ctl (output cfg, input sample, input rx_bit, input err);
endinterface

// ===== core/cbted_pkg.sv
// types shared by both ends of the bit timing block
package cbted_pkg;

  typedef enum logic [3:0] {
    fld_idle, fld_sof, fld_arb, fld_ctrl, fld_data, fld_crc, fld_crc_del,
    fld_ack_slot, fld_ack_del, fld_eof, fld_ifs, fld_err_frame
  } cbted_field_type;

  typedef struct packed {
    logic        rx_meta;
    logic        rx_sync;
    logic        rx_prev;
    logic [2:0]  hist;
    logic        edge_pend;
    logic [6:0]  psc;
    logic [5:0]  pos;
    logic [2:0]  add;
    logic [2:0]  sub;
    logic        rx_bit;
    logic        sample;
    logic        bit_start;
    logic        can_tx;
    logic        stuff_bit;
    logic [4:0]  err;
    logic [2:0]  same_cnt;
    logic        last_lvl;
    logic [2:0]  eof_cnt;
    logic [14:0] crc;
    logic [14:0] rxcrc;
  } cbted_dev_st_type;

  typedef struct packed {
    logic [31:0] cfg;
    logic [5:0]  status;
    logic        dp_wr;
    logic        dp_cfg;
    logic        dp_stat;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } cbted_ctl_st_type;

endpackage

// ===== tb/cbted_assertions.sv
// concurrent checks on the link between the two ends
`timescale 1ns/1ns
`include "cbted_consts.svh"
module cbted_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] cfg,
  input wire logic        sample,
  input wire logic        rx_bit,
  input wire logic [4:0]  err
);
  logic [4:0]  pr, p1, p2, jw, tq;
  logic [12:0] gap_ff, gap_max;

  assign pr = {2'h0, cfg[24:22]} + 5'h01;
  assign p1 = {2'h0, cfg[18:16]} + 5'h01;
  assign p2 = cfg[15] ? {2'h0, cfg[21:19]} + 5'h01 : p1;
  assign jw = {3'h0, cfg[7:6]} + 5'h01;
  assign tq = 5'h01 + pr + p1 + p2;
  // longest bit is 25 quanta plus four of lengthening
  assign gap_max = ({7'h00, cfg[5:0]} + 13'h0001) * 13'h003a + 13'h0008;

  // restart on a new timing word, the old bit may run at the old rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      gap_ff <= 13'h0000;
    else if (sample || $changed(cfg))
      gap_ff <= 13'h0000;
    else
      gap_ff <= gap_ff + 13'h0001;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cfg_rst; $past(hresetn) == 1'b0 |-> cfg == `CBTED_CFG_RST; endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("timing word reset value");
  property p_tq_range; tq >= 5'h08 && tq <= 5'h19; endproperty
  a_tq_range: assert property (p_tq_range) else $error("bit time out of range");
  property p_seg_order; pr + p1 >= p2; endproperty
  a_seg_order: assert property (p_seg_order) else $error("phase two too long");
  property p_jw; p2 > jw; endproperty
  a_jw: assert property (p_jw) else $error("jump width not below phase two");
  property p_smp_pulse; sample |=> !sample; endproperty
  a_smp_pulse: assert property (p_smp_pulse) else $error("sample pulse too long");
  property p_smp_gap; gap_ff <= gap_max; endproperty
  a_smp_gap: assert property (p_smp_gap) else $error("sample point missing");
  property p_rx_hold; !$stable(rx_bit) |-> sample || $past(sample); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("level moved off sample");
  property p_err_smp; err != 5'h00 |-> sample || $past(sample); endproperty
  a_err_smp: assert property (p_err_smp) else $error("error off sample point");
  property p_err_pulse; err != 5'h00 |=> (err & $past(err)) == 5'h00; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");
  property p_ack_rec; err[`CBTED_ERR_ACK] |-> rx_bit; endproperty
  a_ack_rec: assert property (p_ack_rec) else $error("ack error on dominant");
  property p_form_dom; err[`CBTED_ERR_FORM] |-> !rx_bit; endproperty
  a_form_dom: assert property (p_form_dom) else $error("form error on recessive");
endmodule

// ===== tb/cbted_test.sv
// self-checking bench for both ends of the bit timing block
`timescale 1ns/1ns
module cbted_test;
  import cbted_pkg::*;
  logic            hclk, hresetn, hsel, hwrite, drv, tx, pas;
  logic [31:0]     haddr, hwdata, rd;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  cbted_field_type fld;
  wire             hreadyout, hresp, can_tx, bit_start, rx_valid, rx_level;
  wire  [31:0]     hrdata;
  int              error_cnt, n_checks, wcnt;
  logic [31:0]     tbl [4] = '{32'h00ba_0000, 32'h0092_8001, 32'h0092_8000, 32'h0092_8003};
  int              per [4] = '{20, 40, 20, 80};
  logic [31:0]     bad [3] = '{32'h0000_0000, 32'h0092_80c3, 32'h0038_8003};
  // wired-and bus: either side pulls it dominant
  wire             can_rx = drv & can_tx;

  cbted_link_if link ();
  cbted_ctl_end cbted_ctl_end_i (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  cbted_dev_end cbted_dev_end_i (.hclk(hclk), .hresetn(hresetn), .link(link),
    .can_rx(can_rx), .can_tx(can_tx), .field(fld), .transmitting(tx),
    .passive_err_frame(pas), .tx_bit(1'b1), .bit_start(bit_start), .rx_valid(rx_valid),
    .rx_level(rx_level), .stuff_bit());
  cbted_assertions cbted_assertions_i (.hclk(hclk), .hresetn(hresetn), .cfg(link.cfg),
    .sample(link.sample), .rx_bit(link.rx_bit), .err(link.err));

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic stall;
    error_cnt++;
    stop_test;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hwait;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) stall;
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd = hrdata;
  endtask

  // look a little after the edge so registered pulses have landed
  task automatic wsig(input bit smp);
    wcnt = 0;
    do begin
      @(posedge hclk);
      #1;
      wcnt++;
      if (wcnt > 3000) stall;
    end while ((smp ? rx_valid : bit_start) !== 1'b1);
  endtask

  // one or more bits; bus driven just after bit start, inside the sync quantum
  task automatic row(input cbted_field_type f, input logic t, input logic p,
                     input logic d, input int n, input logic [4:0] e);
    logic [4:0] s;
    repeat (n) begin
      @(posedge hclk);
      fld <= f;
      tx <= t;
      pas <= p;
      wsig(1'b0);
      @(posedge hclk);
      drv <= d;
      wsig(1'b1);
      s = link.err;
      @(posedge hclk);
      #1;
      s = s | link.err;
    end
    chk("err", {27'h0, e}, {27'h0, s});
    chk("level", {31'h0, d}, {31'h0, rx_level});
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    drv = 1'b1;
    tx = 1'b0;
    pas = 1'b0;
    fld = fld_idle;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("cfg", 32'h0092_8000, rd);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 32'h0, tbl[i]);
      ahb(1'b0, 32'h0, 32'h0);
      chk("cfg", tbl[i], rd);
      repeat (3) wsig(1'b1);
      chk("period", per[i], wcnt);
    end
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, 32'h0, bad[i]);
      ahb(1'b0, 32'h0, 32'h0);
      chk("refused cfg", 32'h0092_8003, rd);
    end
    ahb(1'b0, 32'h4, 32'h0);
    chk("status", 32'h60, rd);
    ahb(1'b1, 32'h4, 32'h20);
    ahb(1'b0, 32'h4, 32'h0);
    chk("status", 32'h40, rd);
    wsig(1'b1);
    @(posedge hclk);
    drv <= 1'b0;
    wsig(1'b0);
    chk("hard sync", 32'h1, 32'(wcnt <= 6));
    @(posedge hclk);
    fld <= fld_sof;
    wsig(1'b1);
    chk("first sample", 32'h1, 32'(wcnt >= 53 && wcnt <= 57));
    row(fld_arb,       1'b1, 1'b0, 1'b0, 1, 5'h00);
    row(fld_data,      1'b1, 1'b0, 1'b0, 1, 5'h01);
    row(fld_err_frame, 1'b1, 1'b1, 1'b0, 1, 5'h00);
    row(fld_data,      1'b0, 1'b0, 1'b1, 6, 5'h08);
    row(fld_crc_del,   1'b1, 1'b0, 1'b0, 1, 5'h05);
    row(fld_ack_slot,  1'b1, 1'b0, 1'b1, 1, 5'h02);
    row(fld_ack_slot,  1'b1, 1'b0, 1'b0, 1, 5'h00);
    row(fld_ack_del,   1'b0, 1'b0, 1'b0, 1, 5'h04);
    row(fld_eof,       1'b0, 1'b0, 1'b1, 6, 5'h00);
    row(fld_eof,       1'b0, 1'b0, 1'b0, 1, 5'h00);
    row(fld_ifs,       1'b0, 1'b0, 1'b0, 1, 5'h04);
    ahb(1'b0, 32'h4, 32'h0);
    chk("sticky errors", 32'h0f, rd);
    ahb(1'b1, 32'h4, 32'h1f);
    ahb(1'b0, 32'h4, 32'h0);
    chk("cleared errors", 32'h00, rd);
    stop_test;
  end
endmodule
